// ===== logic/hdsp_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts for the serial port
// Assumes: Included by bare name
// Notes:   Registers are 32-bit aligned words on classic Wishbone
`ifndef HDSP_CONSTS_SVH
`define HDSP_CONSTS_SVH

// ============================================================
// Register map
`define HDSP_ADDR_DATA      8'h00
`define HDSP_ADDR_CTRL      8'h04
`define HDSP_ADDR_OPTS      8'h08

// ============================================================
// Control register fields
`define HDSP_CR_RX_READY_FLAG       7
`define HDSP_CR_TXEMPTY     6
`define HDSP_CR_RX_IRQ_ENABLE       5
`define HDSP_CR_TX_IRQ_ENABLE       4
`define HDSP_CR_BAUD_HI     3
`define HDSP_CR_BAUD_LO     1
`define HDSP_CR_NINTH       0
`define HDSP_CR_RESET       8'h00

// ============================================================
// Options register fields
`define HDSP_OPT_LONG       0
`define HDSP_OPT_BUSY       1

// ============================================================
// Divisors from an 8 MHz reference, rescaled to the core clock
`define HDSP_REF_HZ         8000000
`define HDSP_CLK_HZ         125000000
`define HDSP_DIV0           6656
`define HDSP_DIV1           3328
`define HDSP_DIV2           1664
`define HDSP_DIV3           832
`define HDSP_DIV4           416
`define HDSP_DIV5           256
`define HDSP_DIV6           208
`define HDSP_DIV7           104
`define HDSP_OVERSAMPLE     8
`define HDSP_SAMPLE_A       3
`define HDSP_SAMPLE_B       4
`define HDSP_SAMPLE_C       5

`endif

// ===== logic/hdsp_pkg.sv
// Purpose: Types for the half-duplex serial port
// Assumes: Nothing
// Notes:   Gray codes along the normal path
package hdsp_pkg;

	typedef enum logic [1:0]
	{
		HDSP_IDLE  = 2'b00,
		HDSP_START = 2'b01,
		HDSP_DATA  = 2'b11,
		HDSP_STOP  = 2'b10
	} hdsp_state_e;

	typedef logic [7:0] hdsp_byte_t;

endpackage

// ===== logic/hdsp_serial_port.sv
// Purpose: Half-duplex asynchronous serial port with Wishbone register access
// Assumes: Inputs synchronous to clk_in; software sets port level high when idle
// Notes:   Frame length fixed by LONG_FRAME parameter
// What this block does
// - Half-duplex only, frame length fixed at build
// - Ten-bit frame: optional automatic even parity
// - Received bytes buffered; transmit goes straight out
// - Transmit start aborts ongoing reception
// - Eleven-bit frame inverts transmit line
// - Output select inactive when not transmitting
// - Divider gives eight times baud sampling
// - Three samples, two-of-three majority per bit
// - Start and stop generated automatically
// - Data write starts transmission with settings
// - Ninth bit persists, overwritten by reception
// - Low start bit, then data LSB first
// - High stop bit, then release output select
// - Transmit-empty flag set, cleared, software settable
// - Frame layouts: 8+1 or 9+1 payload/stop
// - Idle falling edge, wait one start bit
// - Eight bits to data, ninth or parity
// - Stop wait, buffer, set receive-ready flag
// - Separate interrupt enables per flag
// - Runs from free clock during wait mode
// - Three-bit baud select, immediate effect
// - Parity bit zero means even parity good
// - Receive flag clearable; enables leave flags alone
`timescale 1ns/1ps
`include "hdsp_consts.svh"

module hdsp_serial_port
#(
	parameter bit LONG_FRAME = 1'b0
)
(
	input  wire logic          clk_in,
	input  wire logic          rstn_in,
	input  wire logic          wb_cyc_in,
	input  wire logic          wb_stb_in,
	input  wire logic          wb_we_in,
	input  wire logic [7:0]    wb_adr_in,
	input  wire logic [3:0]    wb_sel_in,
	input  wire logic [31:0]   wb_dat_in,
	output logic      [31:0]   wb_dat_out,
	output logic               wb_ack_out,
	input  wire logic          rx_pin_in,
	input  wire logic          port_out_value_in,
	output logic               serial_out_pin_out,
	output logic               serial_output_select_out,
	output logic               tx_irq_out,
	output logic               rx_irq_out
);
	import hdsp_pkg::*;

	// ============================================================
	// Bus decode
	logic              wr_stb;
	logic              rd_stb;
	logic              wr_data;
	logic              wr_ctrl;
	logic              rd_data;
	logic              ack_q;

	assign wr_stb  = wb_cyc_in && wb_stb_in && wb_we_in && !ack_q;
	assign rd_stb  = wb_cyc_in && wb_stb_in && !wb_we_in && !ack_q;
	assign wr_data = wr_stb && (wb_adr_in == `HDSP_ADDR_DATA) && wb_sel_in[0];
	assign wr_ctrl = wr_stb && (wb_adr_in == `HDSP_ADDR_CTRL) && wb_sel_in[0];
	assign rd_data = rd_stb && (wb_adr_in == `HDSP_ADDR_DATA);

	// ============================================================
	// Registers
	logic              rx_ready_flag_q;
	logic              tx_empty_flag_q;
	logic              rx_irq_enable_q;
	logic              tx_irq_enable_q;
	logic [2:0]        baud_select_q;
	logic              parity_or_ninth_bit_q;
	hdsp_byte_t        rx_buf_q;
	logic              tx_done;
	logic              rx_done;
	logic              rx_ninth;
	hdsp_byte_t        rx_shift_q;

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			rx_irq_enable_q       <= 1'b0;
			tx_irq_enable_q       <= 1'b0;
			baud_select_q         <= 3'h0;
			parity_or_ninth_bit_q <= 1'b0;
		end
		else
		begin
			if (wr_ctrl)
			begin
				rx_irq_enable_q <= wb_dat_in[`HDSP_CR_RX_IRQ_ENABLE];
				tx_irq_enable_q <= wb_dat_in[`HDSP_CR_TX_IRQ_ENABLE];
				baud_select_q   <= wb_dat_in[`HDSP_CR_BAUD_HI:`HDSP_CR_BAUD_LO];
			end
			if (rx_done)
				parity_or_ninth_bit_q <= rx_ninth;
			else if (wr_ctrl)
				parity_or_ninth_bit_q <= wb_dat_in[`HDSP_CR_NINTH];
		end
	end

	// Set wins over software clear
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			tx_empty_flag_q <= 1'b0;
		else if (tx_done)
			tx_empty_flag_q <= 1'b1;
		else if (wr_data)
			tx_empty_flag_q <= 1'b0;
		else if (wr_ctrl)
			tx_empty_flag_q <= wb_dat_in[`HDSP_CR_TXEMPTY];
	end

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			rx_ready_flag_q <= 1'b0;
		else if (rx_done)
			rx_ready_flag_q <= 1'b1;
		else if (wr_ctrl)
			rx_ready_flag_q <= wb_dat_in[`HDSP_CR_RX_READY_FLAG];
	end

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			rx_buf_q <= 8'h00;
		else if (rx_done)
			rx_buf_q <= rx_shift_q;
	end

	// ============================================================
	// Baud divider: eight-times sample enable
	logic [15:0]       div_cnt_q;
	logic [15:0]       div_max;
	logic              tick;
	logic [15:0]       ref_div;

	always_comb
	begin
		case (baud_select_q)
			3'h0:    ref_div = 16'(`HDSP_DIV0);
			3'h1:    ref_div = 16'(`HDSP_DIV1);
			3'h2:    ref_div = 16'(`HDSP_DIV2);
			3'h3:    ref_div = 16'(`HDSP_DIV3);
			3'h4:    ref_div = 16'(`HDSP_DIV4);
			3'h5:    ref_div = 16'(`HDSP_DIV5);
			3'h6:    ref_div = 16'(`HDSP_DIV6);
			default: ref_div = 16'(`HDSP_DIV7);
		endcase
		// Rescale reference divisor to core clock, per sample tick
		div_max = 16'((32'(ref_div) * (`HDSP_CLK_HZ / 1000)) /
			((`HDSP_REF_HZ / 1000) * `HDSP_OVERSAMPLE) - 32'd1);
	end

	assign tick = (div_cnt_q == 16'h0000);

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			div_cnt_q <= 16'h0000;
		else if (tick || div_cnt_q > div_max)
			div_cnt_q <= div_max;
		else
			div_cnt_q <= div_cnt_q - 16'h0001;
	end

	// ============================================================
	// Transmitter
	localparam int NPAY = LONG_FRAME ? 9 : 8;
	hdsp_state_e       tx_state_q;
	logic [2:0]        tx_phase_q;
	logic [3:0]        tx_bit_q;
	logic [8:0]        tx_shift_q;
	logic              tx_level_q;
	logic              tx_active;
	logic              tx_end_tick;
	logic              par7;

	assign tx_active   = (tx_state_q != HDSP_IDLE);
	assign tx_end_tick = tick && (tx_phase_q == 3'h7);
	assign par7        = ^wb_dat_in[6:0];
	assign tx_done     = (tx_state_q == HDSP_STOP) && tx_end_tick;

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			tx_state_q <= HDSP_IDLE;
			tx_phase_q <= 3'h0;
			tx_bit_q   <= 4'h0;
			tx_shift_q <= 9'h000;
			tx_level_q <= 1'b1;
		end
		else if (wr_data)
		begin
			tx_state_q <= HDSP_START;
			tx_phase_q <= 3'h0;
			tx_bit_q   <= 4'h0;
			tx_level_q <= 1'b0;
			if (LONG_FRAME)
				tx_shift_q <= {parity_or_ninth_bit_q, wb_dat_in[7:0]};
			else if (parity_or_ninth_bit_q)
				tx_shift_q <= {1'b1, par7, wb_dat_in[6:0]};
			else
				tx_shift_q <= {1'b1, wb_dat_in[7:0]};
		end
		else if (tick)
		begin
			tx_phase_q <= tx_phase_q + 3'h1;
			if (tx_phase_q == 3'h7)
			begin
				case (tx_state_q)
					HDSP_START:
					begin
						tx_state_q <= HDSP_DATA;
						tx_level_q <= tx_shift_q[0];
						tx_shift_q <= {1'b1, tx_shift_q[8:1]};
					end
					HDSP_DATA:
					begin
						tx_bit_q <= tx_bit_q + 4'h1;
						if (tx_bit_q == 4'(NPAY - 1))
						begin
							tx_state_q <= HDSP_STOP;
							tx_level_q <= 1'b1;
						end
						else
						begin
							tx_level_q <= tx_shift_q[0];
							tx_shift_q <= {1'b1, tx_shift_q[8:1]};
						end
					end
					HDSP_STOP:
						tx_state_q <= HDSP_IDLE;
					default:
						tx_state_q <= HDSP_IDLE;
				endcase
			end
		end
	end

	// ============================================================
	// Receiver
	hdsp_state_e       rx_state_q;
	logic [2:0]        rx_phase_q;
	logic [3:0]        rx_bit_q;
	logic [2:0]        rx_smp_q;
	logic              rx_prev_q;
	logic              rx_ninth_q;
	logic              vote;

	assign vote     = (rx_smp_q[0] & rx_smp_q[1]) | (rx_smp_q[0] & rx_smp_q[2]) |
		(rx_smp_q[1] & rx_smp_q[2]);
	assign rx_ninth = LONG_FRAME ? rx_ninth_q : ^rx_shift_q;
	assign rx_done  = (rx_state_q == HDSP_STOP) && tick && (rx_phase_q == 3'h7)
		&& !tx_active && !wr_data;

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
			rx_prev_q <= 1'b1;
		else if (tick)
			rx_prev_q <= rx_pin_in;
	end

	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			rx_state_q <= HDSP_IDLE;
			rx_phase_q <= 3'h0;
			rx_bit_q   <= 4'h0;
			rx_smp_q   <= 3'h7;
			rx_shift_q <= 8'h00;
			rx_ninth_q <= 1'b0;
		end
		else if (tx_active || wr_data)
			rx_state_q <= HDSP_IDLE;
		else if (tick)
		begin
			rx_phase_q <= rx_phase_q + 3'h1;
			if (rx_phase_q == 3'(`HDSP_SAMPLE_A))
				rx_smp_q[0] <= rx_pin_in;
			if (rx_phase_q == 3'(`HDSP_SAMPLE_B))
				rx_smp_q[1] <= rx_pin_in;
			if (rx_phase_q == 3'(`HDSP_SAMPLE_C))
				rx_smp_q[2] <= rx_pin_in;
			case (rx_state_q)
				HDSP_IDLE:
					if (rx_prev_q && !rx_pin_in)
					begin
						rx_state_q <= HDSP_START;
						rx_phase_q <= 3'h1;
						rx_bit_q   <= 4'h0;
					end
				HDSP_START:
					if (rx_phase_q == 3'h7)
						rx_state_q <= HDSP_DATA;
				HDSP_DATA:
					if (rx_phase_q == 3'h7)
					begin
						rx_bit_q <= rx_bit_q + 4'h1;
						if (rx_bit_q == 4'h8)
							rx_ninth_q <= vote;
						else
							rx_shift_q <= {vote, rx_shift_q[7:1]};
						if (rx_bit_q == 4'(NPAY - 1))
							rx_state_q <= HDSP_STOP;
					end
				HDSP_STOP:
					if (rx_phase_q == 3'h7)
						rx_state_q <= HDSP_IDLE;
				default:
					rx_state_q <= HDSP_IDLE;
			endcase
		end
	end

	// ============================================================
	// Outputs
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			serial_output_select_out <= 1'b0;
			serial_out_pin_out       <= 1'b1;
			tx_irq_out               <= 1'b0;
			rx_irq_out               <= 1'b0;
		end
		else
		begin
			serial_output_select_out <= tx_active;
			if (tx_active)
				serial_out_pin_out <= LONG_FRAME ? ~tx_level_q : tx_level_q;
			else
				serial_out_pin_out <= port_out_value_in;
			tx_irq_out <= tx_irq_enable_q && tx_empty_flag_q;
			rx_irq_out <= rx_irq_enable_q && rx_ready_flag_q;
		end
	end

	// ============================================================
	// Bus answer: one wait state, unmapped reads zero
	always_ff @(posedge clk_in)
	begin
		if (!rstn_in)
		begin
			ack_q      <= 1'b0;
			wb_ack_out <= 1'b0;
			wb_dat_out <= 32'h0000_0000;
		end
		else
		begin
			ack_q      <= wr_stb || rd_stb;
			wb_ack_out <= wr_stb || rd_stb;
			if (rd_data)
				wb_dat_out <= {24'h000000, rx_buf_q};
			else if (rd_stb && wb_adr_in == `HDSP_ADDR_CTRL)
				wb_dat_out <= {24'h000000, rx_ready_flag_q, tx_empty_flag_q,
					rx_irq_enable_q, tx_irq_enable_q, baud_select_q,
					parity_or_ninth_bit_q};
			else if (rd_stb && wb_adr_in == `HDSP_ADDR_OPTS)
				wb_dat_out <= {30'h0, tx_active, LONG_FRAME};
			else
				wb_dat_out <= 32'h0000_0000;
		end
	end

	// Clock runs free of processor wait state
endmodule

// ===== tb/hdsp_serial_port_sva.sv
// Purpose: Port-level checks for the serial port
// Assumes: Baud code 7 whenever a frame is sent
// Notes:   Bound from the bench top file
`timescale 1ns/1ps
module hdsp_serial_port_sva
#(
	parameter bit LONG_FRAME = 1'b0,
	parameter int TICK_CYC   = 203
)
(
	input wire logic        clk_in,
	input wire logic        rstn_in,
	input wire logic        wb_cyc_in,
	input wire logic        wb_stb_in,
	input wire logic        wb_we_in,
	input wire logic [7:0]  wb_adr_in,
	input wire logic [3:0]  wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic        wb_ack_out,
	input wire logic        rx_pin_in,
	input wire logic        port_out_value_in,
	input wire logic        serial_out_pin_out,
	input wire logic        serial_output_select_out,
	input wire logic        tx_irq_out,
	input wire logic        rx_irq_out
);
	int sel_cnt_q;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	// ========================================
	// Cycles with the output select high
	always_ff @(posedge clk_in)
	begin
		if (!serial_output_select_out)
			sel_cnt_q <= 0;
		else
			sel_cnt_q <= sel_cnt_q + 1;
	end
	sequence s_take;
		wb_cyc_in && wb_stb_in && !wb_ack_out;
	endsequence
	sequence s_dwrite;
		s_take ##0 (wb_we_in && wb_adr_in == 8'h00 && wb_sel_in[0]);
	endsequence
	// ========================================
	// Assertions
	AST_ACK_PULSE: assert property (wb_ack_out |=> !wb_ack_out)
		else $error("ack longer than one cycle");
	AST_ACK_TAKE: assert property (s_take |=> wb_ack_out)
		else $error("ack late");
	AST_UPPER_ZERO: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h000000)
		else $error("upper read bits set");
	AST_START_BIT: assert property (
		s_dwrite |-> ##[1:3] (serial_output_select_out && serial_out_pin_out == LONG_FRAME))
		else $error("no start bit after data write");
	AST_PORT_PASS: assert property (
		(!serial_output_select_out && $past(!serial_output_select_out)
		&& $stable(port_out_value_in)) |-> serial_out_pin_out == port_out_value_in)
		else $error("pin not following port value");
	AST_FRAME_LEN: assert property (
		$fell(serial_output_select_out) |-> sel_cnt_q inside
		{[(LONG_FRAME ? 87 : 79) * TICK_CYC + 1 : (LONG_FRAME ? 88 : 80) * TICK_CYC]})
		else $error("frame length wrong");
	AST_STOP_LEVEL: assert property (
		$fell(serial_output_select_out) |-> $past(serial_out_pin_out, 2) == !LONG_FRAME)
		else $error("stop level wrong");
	AST_RX_QUIET_TX: assert property (
		$rose(rx_irq_out) |-> !$past(serial_output_select_out))
		else $error("receive completed during transmit");
	AST_RESET_VALS: assert property (
		$rose(rstn_in) |-> (!serial_output_select_out && !tx_irq_out && !rx_irq_out
		&& !wb_ack_out && serial_out_pin_out))
		else $error("reset values wrong");
endmodule

// ===== tb/hdsp_remote_station.sv
// Purpose: Remote station sending frames to the port
// Assumes: Ten-bit frames at baud code 7
// Notes:   Line idles high between frames
`timescale 1ns/1ps
module hdsp_remote_station
#(
	parameter int TICK = 203
)
(
	input  wire logic clk_in,
	output logic      line_out
);
	logic [9:0] frame;
	initial line_out = 1'b1;
	task automatic send(input logic [7:0] b);
		frame = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk_in);
			line_out <= frame[i];
			repeat (8 * TICK - 1) @(posedge clk_in);
		end
	endtask
endmodule

// ===== tb/test_half_duplex_async_serial_port.sv
// Purpose: Self-checking bench for the serial port
// Assumes: Ten-bit frame build, baud code 7
// Notes:   Bit time is 1624 clocks; second instance checks the eleven-bit build
`timescale 1ns/1ps
module test_half_duplex_async_serial_port;
	import hdsp_pkg::*;
	localparam int BIT = 1624;
	logic        clk_in, rstn_in, wb_cyc, wb_stb, wb_we, wb_ack;
	logic [7:0]  wb_adr;
	logic [31:0] wb_wdat, wb_rdat, rd;
	logic        rx_line, port_v, pin, osel, tx_irq, rx_irq;
	logic        pin_l, osel_l;
	int          err_total, n_compared;
	hdsp_serial_port DUT (.clk_in(clk_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc),
		.wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr), .wb_sel_in(4'hF),
		.wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack), .rx_pin_in(rx_line),
		.port_out_value_in(port_v), .serial_out_pin_out(pin),
		.serial_output_select_out(osel), .tx_irq_out(tx_irq), .rx_irq_out(rx_irq));
	hdsp_serial_port #(.LONG_FRAME(1'b1)) DUT_LONG (.clk_in(clk_in), .rstn_in(rstn_in),
		.wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
		.wb_sel_in(4'hF), .wb_dat_in(wb_wdat), .wb_dat_out(), .wb_ack_out(),
		.rx_pin_in(rx_line), .port_out_value_in(port_v), .serial_out_pin_out(pin_l),
		.serial_output_select_out(osel_l), .tx_irq_out(), .rx_irq_out());
	hdsp_remote_station u_rem (.clk_in(clk_in), .line_out(rx_line));
	initial
	begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end
	task automatic tally_and_finish;
		$display("compared %0d errors %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stall;
		err_total++;
		$display("mismatch at %0t: wait ran out", $time);
		tally_and_finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_in);
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= w;
		wb_adr <= a;
		wb_wdat <= d;
		k = 0;
		do
		begin
			@(posedge clk_in);
			k++;
		end
		while (wb_ack !== 1'b1 && k < 50);
		if (wb_ack !== 1'b1)
			stall;
		rd = wb_rdat;
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
	endtask
	task automatic t_reset;
		wb(0, 8'h04, 0);
		chk(rd, 0);
		wb(0, 8'h08, 0);
		chk(rd, 0);
		wb(0, 8'h0C, 0);
		chk(rd, 0);
		port_v <= 1'b0;
		repeat (3) @(posedge clk_in);
		chk(pin, 0);
		port_v <= 1'b1;
	endtask
	task automatic t_tx(input logic [7:0] cv, input logic [7:0] dv, input logic [9:0] ex);
		int k;
		logic [9:0] ex_l;
		ex_l = {cv[0], dv, 1'b0};
		wb(1, 8'h04, cv);
		wb(1, 8'h00, dv);
		for (k = 0; k < 9 && osel !== 1'b1; k++)
			@(posedge clk_in);
		if (osel !== 1'b1)
			stall;
		repeat (BIT / 2) @(posedge clk_in);
		for (k = 0; k < 10; k++)
		begin
			chk(pin, ex[k]);
			chk(pin_l, !ex_l[k]);
			repeat (BIT) @(posedge clk_in);
		end
		chk(osel, 0);
		repeat (3) @(posedge clk_in);
		chk(tx_irq, cv[4]);
		for (k = 0; k < 2 * BIT && osel_l !== 1'b0; k++)
			@(posedge clk_in);
		chk(osel_l, 0);
		wb(0, 8'h04, 0);
		chk(rd[6], 1);
	endtask
	task automatic t_flags;
		wb(1, 8'h04, 8'h1E);
		repeat (3) @(posedge clk_in);
		chk(tx_irq, 0);
		wb(1, 8'h04, 8'h5E);
		repeat (3) @(posedge clk_in);
		chk(tx_irq, 1);
		wb(1, 8'h04, 8'h0E);
	endtask
	task automatic t_rx;
		int k;
		wb(1, 8'h04, 8'h2E);
		u_rem.send(8'h5B);
		for (k = 0; k < BIT && rx_irq !== 1'b1; k++)
			@(posedge clk_in);
		chk(rx_irq, 1);
		wb(0, 8'h00, 0);
		chk(rd, 8'h5B);
		wb(0, 8'h04, 0);
		chk(rd[7], 1);
		chk(rd[0], 1);
		wb(1, 8'h04, 8'h8E);
		wb(0, 8'h04, 0);
		chk(rd[7], 1);
		chk(rd[0], 0);
		chk(rx_irq, 0);
		wb(1, 8'h04, 8'h0E);
		wb(0, 8'h04, 0);
		chk(rd[7], 0);
	endtask
	task automatic t_abort;
		int k;
		fork
			u_rem.send(8'h33);
			begin
				repeat (3 * BIT) @(posedge clk_in);
				wb(1, 8'h00, 8'hFF);
			end
		join
		for (k = 0; k < 4 * BIT && osel !== 1'b0; k++)
			@(posedge clk_in);
		if (k == 4 * BIT)
			stall;
		repeat (2 * BIT) @(posedge clk_in);
		wb(0, 8'h04, 0);
		chk(rd[7], 0);
		chk(rd[6], 1);
	endtask
	initial
	begin
		rstn_in = 1'b0;
		wb_cyc = 1'b0;
		wb_stb = 1'b0;
		wb_we = 1'b0;
		wb_adr = 8'h00;
		wb_wdat = 0;
		port_v = 1'b1;
		err_total = 0;
		n_compared = 0;
		repeat (3) @(posedge clk_in);
		rstn_in <= 1'b1;
		t_reset;
		t_tx(8'h1E, 8'hA5, {1'b1, 8'hA5, 1'b0});
		t_tx(8'h0F, 8'h07, {1'b1, 1'b1, 7'h07, 1'b0});
		t_flags;
		t_rx;
		t_abort;
		tally_and_finish;
	end
endmodule
bind hdsp_serial_port hdsp_serial_port_sva #(.LONG_FRAME(LONG_FRAME)) u_sva (
	.clk_in(clk_in), .rstn_in(rstn_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
	.wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
	.wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
	.rx_pin_in(rx_pin_in), .port_out_value_in(port_out_value_in),
	.serial_out_pin_out(serial_out_pin_out),
	.serial_output_select_out(serial_output_select_out),
	.tx_irq_out(tx_irq_out), .rx_irq_out(rx_irq_out));
